// ### logic/carrier_mixer.sv
/*
 * Complex carrier mixer: rotates one I/Q sample by a multiple of 45
 * degrees chosen by a three-bit carrier phase, one registered stage.
 * Assumes the caller advances the phase once per converter sample.
 */
`timescale 1ns/100ps

module carrier_mixer
    import interp_path_pkg::*;
(
    input  wire logic                     pclk,
    input  wire logic                     presetn,
    input  wire logic [2:0]               phase,
    input  wire interp_path_pkg::sample_t in_i,
    input  wire interp_path_pkg::sample_t in_q,
    output interp_path_pkg::sample_t      out_i,
    output interp_path_pkg::sample_t      out_q
);
    import interp_path_pkg::*;

    coef_t       cos_v;
    coef_t       sin_v;
    logic [31:0] rot;

    // Carrier table; phase 1 gives r(I+Q) on I and r(Q-I) on Q.
    always_comb begin
        case (phase)
            3'd0:    begin cos_v = `Q_UNITY;      sin_v = '0;           end
            3'd1:    begin cos_v = `Q_ROOT_HALF;  sin_v = `Q_ROOT_HALF; end
            3'd2:    begin cos_v = '0;            sin_v = `Q_UNITY;     end
            3'd3:    begin cos_v = -`Q_ROOT_HALF; sin_v = `Q_ROOT_HALF; end
            3'd4:    begin cos_v = -`Q_UNITY;     sin_v = '0;           end
            3'd5:    begin cos_v = -`Q_ROOT_HALF; sin_v = -`Q_ROOT_HALF;end
            3'd6:    begin cos_v = '0;            sin_v = -`Q_UNITY;    end
            default: begin cos_v = `Q_ROOT_HALF;  sin_v = -`Q_ROOT_HALF;end
        endcase
        rot = rotate(in_i, in_q, cos_v, sin_v);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            out_i <= '0;
            out_q <= '0;
        end else begin
            out_i <= rot[31:16];
            out_q <= rot[15:0];
        end
    end

endmodule : carrier_mixer

// ### logic/interp_modulator_invsinc_path.sv
/*
 * Transmit datapath of a dual converter: APB configuration registers,
 * sample intake (dual or interleaved), zero-order hold interpolation
 * with a two-tap pass band filter that can be shifted, complex carrier
 * mixing and an optional inverse sinc stage.
 * Assumes pclk is the converter sample clock and that the sample source
 * runs on pclk and honours in_ready.
 */
// The APB interface to the registers and the placing of the registers were left to the implementer.
`timescale 1ns/100ps

module interp_modulator_invsinc_path
    import interp_path_pkg::*;
(
    input  wire logic                     pclk,
    input  wire logic                     presetn,
    input  wire logic [7:0]               paddr,
    input  wire logic                     psel,
    input  wire logic                     penable,
    input  wire logic                     pwrite,
    input  wire logic [31:0]              pwdata,
    output logic [31:0]                   prdata,
    output logic                          pready,
    output logic                          pslverr,
    input  wire interp_path_pkg::sample_t port1_word,
    input  wire interp_path_pkg::sample_t port2_word,
    input  wire logic                     in_valid,
    output logic                          in_ready,
    output interp_path_pkg::sample_t      dac_i,
    output interp_path_pkg::sample_t      dac_q
);
    import interp_path_pkg::*;

    // Configuration and status.
    logic [7:0]  cfg1;
    logic [7:0]  cfg2;
    logic        underrun;

    // Decoded mode.
    logic [1:0]  factor;
    logic [3:0]  mode;
    logic        interleave;
    logic        real_mode;
    logic        invsinc_en;
    logic [4:0]  mode_dec;
    logic        mode_invalid;
    logic        shifted;
    logic [2:0]  step;

    // Sample pacing.
    logic [2:0]  cnt;
    logic [2:0]  next_cnt;
    logic [2:0]  last;
    word_slot_e  slot;
    logic        take;
    logic        commit;

    // Datapath.
    sample_t     pend_i;
    sample_t     hold_i;
    sample_t     hold_q;
    sample_t     prev_i;
    sample_t     prev_q;
    sample_t     filt_i;
    sample_t     filt_q;
    coef_t       shift_c;
    coef_t       shift_s;
    logic [31:0] shift_rot;
    logic [2:0]  phase;
    sample_t     mix_i;
    sample_t     mix_q;
    sample_t     sinc_i;
    sample_t     sinc_q;

    // APB decode.
    logic        access;
    logic        done;
    logic [5:0]  index;
    logic        mapped;

    // Last slot count of a factor: one word every 1, 2, 4 or 8 cycles.
    function automatic logic [2:0] slot_last(input logic [1:0] f);
        case (f)
            `FACTOR_2X: return 3'd1;
            `FACTOR_4X: return 3'd3;
            `FACTOR_8X: return 3'd7;
            default:    return 3'd0;
        endcase
    endfunction : slot_last

    // Maps factor and mode code to {invalid, shifted, carrier step}.
    // The step is the carrier phase advance in eighths of a turn.
    function automatic logic [4:0] decode_mode(input logic [1:0] f,
                                               input logic [3:0] m);
        case (f)
            `FACTOR_8X: return {1'b0, m[0], m[3:1]};
            `FACTOR_4X: begin
                if (m[3]) begin
                    return 5'b1_0_000;
                end
                return {1'b0, m[0], m[2:1], 1'b0};
            end
            `FACTOR_2X: begin
                if (m[3:2] != 2'b00) begin
                    return 5'b1_0_000;
                end
                return {1'b0, m[0], m[1], 2'b00};
            end
            default: begin
                if (m != 4'h0) begin
                    return 5'b1_0_000;
                end
                return 5'b0_0_000;
            end
        endcase
    endfunction : decode_mode

    assign factor     = cfg1[`FACTOR_HI:`FACTOR_LO];
    assign mode       = cfg1[`MODE_HI:`MODE_LO];
    assign interleave = cfg2[`INTERLEAVE_BIT];
    assign real_mode  = cfg2[`REAL_BIT];
    assign invsinc_en = cfg2[`INVSINC_BIT];

    always_comb begin
        mode_dec     = decode_mode(factor, mode);
        mode_invalid = mode_dec[4];
        // Real mode turns off the Q channel, the carrier and the shift.
        shifted      = mode_dec[3] & ~real_mode;
        step         = real_mode ? 3'd0 : mode_dec[2:0];
    end

    // APB slave: one wait state, write and read data at the ready edge.
    assign access = psel & penable;
    assign done   = access & pready;
    assign index  = paddr[7:2];
    assign mapped = (paddr[1:0] == 2'b00) &&
                    (index == `CFG1_INDEX || index == `CFG2_INDEX ||
                     index == `STATUS_INDEX);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= '0;
        end else begin
            pready  <= access & ~pready;
            pslverr <= access & ~pready & ~mapped;
            prdata  <= '0;
            if (access && !pready && !pwrite) begin
                case (index)
                    `CFG1_INDEX:   prdata[7:0] <= cfg1;
                    `CFG2_INDEX:   prdata[7:0] <= cfg2;
                    `STATUS_INDEX: begin
                        prdata[`ST_INVALID_BIT]  <= mode_invalid;
                        prdata[`ST_UNDERRUN_BIT] <= underrun;
                        prdata[`ST_STEP_LO+:3]   <= step;
                        prdata[`ST_SHIFT_BIT]    <= shifted;
                    end
                    default:       prdata <= '0;
                endcase
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg1 <= `CFG1_RESET;
            cfg2 <= `CFG2_RESET;
        end else if (done && pwrite && mapped) begin
            if (index == `CFG1_INDEX) begin
                cfg1 <= {pwdata[`FACTOR_HI:`MODE_LO], 2'b00};
            end
            if (index == `CFG2_INDEX) begin
                cfg2 <= '0;
                cfg2[`INTERLEAVE_BIT] <= pwdata[`INTERLEAVE_BIT];
                cfg2[`REAL_BIT]       <= pwdata[`REAL_BIT];
                cfg2[`INVSINC_BIT]    <= pwdata[`INVSINC_BIT];
            end
        end
    end

    // Sticky underrun: a missing word at a slot sets it, writing a one to
    // its status bit clears it, and a new miss in that cycle wins.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            underrun <= 1'b0;
        end else if (in_ready && !in_valid) begin
            underrun <= 1'b1;
        end else if (done && pwrite && mapped && index == `STATUS_INDEX &&
                     pwdata[`ST_UNDERRUN_BIT]) begin
            underrun <= 1'b0;
        end
    end

    // Word pacing: one word per factor cycles, ready in the slot's cycle.
    always_comb begin
        last     = slot_last(factor);
        next_cnt = (cnt >= last) ? 3'd0 : cnt + 3'd1;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt      <= '0;
            in_ready <= 1'b0;
        end else begin
            cnt      <= next_cnt;
            in_ready <= (next_cnt == last);
        end
    end

    assign take   = in_ready & in_valid;
    assign commit = take & (~interleave | (slot == WORD_Q));

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            slot <= WORD_I;
        end else if (!interleave) begin
            slot <= WORD_I;
        end else if (take) begin
            slot <= (slot == WORD_I) ? WORD_Q : WORD_I;
        end
    end

    // Intake: port one is I, port two is Q; interleaved words pair I first.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pend_i <= '0;
            hold_i <= '0;
            hold_q <= '0;
        end else begin
            if (take && interleave && slot == WORD_I) begin
                pend_i <= port1_word;
            end
            if (commit) begin
                hold_i <= interleave ? pend_i : port1_word;
                if (real_mode) begin
                    hold_q <= '0;
                end else begin
                    hold_q <= interleave ? port1_word
                                         : port2_word;
                end
            end
        end
    end

    // Pass band shift: rotating the delayed tap by pi/factor puts the
    // response peak at half the word rate; the signal itself is untouched.
    always_comb begin
        shift_c = `Q_UNITY;
        shift_s = '0;
        if (shifted) begin
            case (factor)
                `FACTOR_2X: begin
                    shift_c = '0;
                    shift_s = -`Q_UNITY;
                end
                `FACTOR_4X: begin
                    shift_c = `Q_ROOT_HALF;
                    shift_s = -`Q_ROOT_HALF;
                end
                `FACTOR_8X: begin
                    shift_c = `Q_COS_22P5;
                    shift_s = -`Q_SIN_22P5;
                end
                default: begin
                    shift_c = `Q_UNITY;
                    shift_s = '0;
                end
            endcase
        end
        shift_rot = rotate(prev_i, prev_q, shift_c, shift_s);
    end

    // Two-tap interpolation filter on the held samples above 1x, unity DC gain when not shifted.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prev_i <= '0;
            prev_q <= '0;
            filt_i <= '0;
            filt_q <= '0;
        end else begin
            prev_i <= hold_i;
            prev_q <= hold_q;
            if (factor == `FACTOR_1X) begin
                filt_i <= hold_i;
                filt_q <= hold_q;
            end else begin
                filt_i <= avg(hold_i, shift_rot[31:16]);
                filt_q <= avg(hold_q, shift_rot[15:0]);
            end
        end
    end

    function automatic sample_t avg(input sample_t a, input sample_t b);
        logic signed [16:0] s;
        s = 17'(a) + 17'(b) + 17'sd1;
        return s[16:1];
    endfunction : avg

    // Carrier phase in eighths of a turn, advanced once per sample.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            phase <= '0;
        end else if (step == 3'd0) begin
            phase <= '0;
        end else begin
            phase <= phase + step;
        end
    end

    // Step 4 gives +1,-1 per channel, 2 and 6 the quarter-rate sequences,
    // 1 and its odd multiples the eighth-rate ones.
    carrier_mixer mixer (
        .pclk    (pclk),
        .presetn (presetn),
        .phase   (phase),
        .in_i    (filt_i),
        .in_q    (filt_q),
        .out_i   (mix_i),
        .out_q   (mix_q)
    );

    inverse_sinc_fir sinc_i_fir (
        .pclk    (pclk),
        .presetn (presetn),
        .in_x    (mix_i),
        .out_y   (sinc_i)
    );

    inverse_sinc_fir sinc_q_fir (
        .pclk    (pclk),
        .presetn (presetn),
        .in_x    (mix_q),
        .out_y   (sinc_q)
    );

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dac_i <= '0;
            dac_q <= '0;
        end else begin
            dac_i <= invsinc_en ? sinc_i : mix_i;
            dac_q <= real_mode ? '0 :
                     (invsinc_en ? sinc_q : mix_q);
        end
    end

endmodule : interp_modulator_invsinc_path

// ### logic/interp_path_params.svh
/*
 * Named constants of the interpolating modulator path: register indices,
 * field positions, reset values, carrier and filter coefficients.
 * Assumes inclusion by bare name from the package and the design modules.
 */
`ifndef INTERP_PATH_PARAMS_SVH
`define INTERP_PATH_PARAMS_SVH

// Register indices; the byte address on APB is four times the index.
`define CFG1_INDEX      6'h01
`define CFG2_INDEX      6'h02
`define STATUS_INDEX    6'h03

`define CFG1_RESET      8'h00
`define CFG2_RESET      8'h00

// Configuration register 1 fields.
`define FACTOR_HI       7
`define FACTOR_LO       6
`define MODE_HI         5
`define MODE_LO         2

// Configuration register 2 bits.
`define INTERLEAVE_BIT  6
`define REAL_BIT        5
`define INVSINC_BIT     3

// Status register bits.
`define ST_INVALID_BIT  0
`define ST_UNDERRUN_BIT 1
`define ST_STEP_LO      2
`define ST_SHIFT_BIT    5

// Interpolation factor codes.
`define FACTOR_1X       2'b00
`define FACTOR_2X       2'b01
`define FACTOR_4X       2'b10
`define FACTOR_8X       2'b11

// Q14 carrier and rotation coefficients.
`define Q_SHIFT         14
`define Q_ROUND         33'sh0_0000_2000
`define Q_UNITY         16'sh4000
`define Q_ROOT_HALF     16'sh2d41
`define Q_COS_22P5      16'sh3b21
`define Q_SIN_22P5      16'sh187e
`define SAT_MAX         33'sh0_0000_7fff
`define SAT_MIN         33'sh1_ffff_8000

// Nine-tap inverse sinc coefficients, outermost pair first.
`define TAP_OUTER       26'sd2
`define TAP_SECOND      -26'sd4
`define TAP_THIRD       26'sd10
`define TAP_FOURTH      -26'sd35
`define TAP_CENTRE      26'sd401
`define INVSINC_TAPS    9
`define INVSINC_SHIFT   9
`define INVSINC_ROUND   26'sd256

`endif

// ### logic/interp_path_pkg.sv
/*
 * Types and shared arithmetic of the interpolating modulator path.
 * Assumes the constants header is on the include path.
 */
`include "interp_path_params.svh"

package interp_path_pkg;

    typedef logic signed [15:0] sample_t;
    typedef logic signed [15:0] coef_t;

    typedef enum logic [1:0] {
        WORD_I,
        WORD_Q
    } word_slot_e;

    // Clamps a wide signed value to the sample range.
    function automatic sample_t sat16(input logic signed [32:0] v);
        if (v > `SAT_MAX) begin
            return 16'sh7fff;
        end else if (v < `SAT_MIN) begin
            return 16'sh8000;
        end
        return v[15:0];
    endfunction : sat16

    // Rotates by minus the angle whose Q14 cosine and sine are given:
    // out_i = i*c + q*s, out_q = q*c - i*s, rounded and saturated.
    function automatic logic [31:0] rotate(input sample_t i,
                                           input sample_t q,
                                           input coef_t   c,
                                           input coef_t   s);
        logic signed [31:0] ic;
        logic signed [31:0] qs;
        logic signed [31:0] qc;
        logic signed [31:0] is_;
        logic signed [32:0] ai;
        logic signed [32:0] aq;
        ic  = i * c;
        qs  = q * s;
        qc  = q * c;
        is_ = i * s;
        ai  = {ic[31], ic} + {qs[31], qs} + `Q_ROUND;
        aq  = {qc[31], qc} - {is_[31], is_} + `Q_ROUND;
        return {sat16(ai >>> `Q_SHIFT), sat16(aq >>> `Q_SHIFT)};
    endfunction : rotate

endpackage : interp_path_pkg

// ### logic/inverse_sinc_fir.sv
/*
 * Nine-tap symmetric inverse sinc FIR for one channel, scaled by 1/512
 * so the DC gain of 347/512 gives about 3.4 dB of insertion loss.
 * Assumes one new sample every clock.
 */
`timescale 1ns/100ps

module inverse_sinc_fir
    import interp_path_pkg::*;
(
    input  wire logic                     pclk,
    input  wire logic                     presetn,
    input  wire interp_path_pkg::sample_t in_x,
    output interp_path_pkg::sample_t      out_y
);
    import interp_path_pkg::*;

    sample_t            taps [`INVSINC_TAPS];
    logic signed [25:0] acc;
    logic signed [25:0] scaled;

    function automatic logic signed [25:0] pair(input sample_t a,
                                                input sample_t b);
        return 26'(a) + 26'(b);
    endfunction : pair

    always_comb begin
        acc = `TAP_OUTER * pair(taps[0], taps[8])
            + `TAP_SECOND * pair(taps[1], taps[7])
            + `TAP_THIRD * pair(taps[2], taps[6])
            + `TAP_FOURTH * pair(taps[3], taps[5])
            + `TAP_CENTRE * 26'(taps[4]);
        scaled = (acc + `INVSINC_ROUND) >>> `INVSINC_SHIFT;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int k = 0; k < `INVSINC_TAPS; k++) begin
                taps[k] <= '0;
            end
            out_y <= '0;
        end else begin
            taps[0] <= in_x;
            for (int k = 1; k < `INVSINC_TAPS; k++) begin
                taps[k] <= taps[k-1];
            end
            out_y <= sat16({{7{scaled[25]}}, scaled});
        end
    end

endmodule : inverse_sinc_fir

// ### testbench/baseband_source.sv
/* Baseband sample source feeding the path's word ports.
   Assumes the bench sets the words and stalls it on purpose. */
`timescale 1ns/100ps
module baseband_source (
    input  wire logic                     pclk,
    input  wire logic                     presetn,
    input  wire logic                     in_ready,
    input  wire logic                     stall,
    input  wire logic                     interleave,
    input  wire interp_path_pkg::sample_t i_word,
    input  wire interp_path_pkg::sample_t q_word,
    output interp_path_pkg::sample_t      port1_word,
    output interp_path_pkg::sample_t      port2_word,
    output logic                          in_valid
);
    import interp_path_pkg::*;
    logic slot;
    assign in_valid = !stall;
    // Complex words: real part on port one, imaginary on port two.
    // While stalled the lines show the inverse of the last word.
    assign port1_word = stall ? ~i_word
                              : (interleave && slot ? q_word : i_word);
    assign port2_word = stall ? ~q_word : q_word;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            slot <= 1'b0;
        end else if (!interleave) begin
            slot <= 1'b0;
        end else if (in_ready && in_valid) begin
            slot <= !slot;
        end
    end
endmodule : baseband_source

// ### testbench/interp_modulator_invsinc_path_bench.sv
/* Self-checking bench of the modulator path with a baseband source.
   Assumes the design, package and checker are compiled before it. */
`timescale 1ns/100ps
module interp_modulator_invsinc_path_bench;
    import interp_path_pkg::*;
    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
    logic        pwrite = 1'b0, stall = 1'b0, interleave = 1'b0;
    logic        pready, pslverr, in_valid, in_ready, err;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    sample_t     port1_word, port2_word, dac_i, dac_q;
    sample_t     i_word = 16'sh1000, q_word = 16'sh0800;
    int          err_total = 0, checked = 0;
    logic signed [31:0] cq [8] = '{32'sh4000, 32'sh2d41, 32'sh0, -32'sh2d41,
        -32'sh4000, -32'sh2d41, 32'sh0, 32'sh2d41};
    sample_t     isinc [9] = '{16'sh0001, -16'sh0002, 16'sh0005, -16'sh0011,
        16'sh00c9, -16'sh0011, 16'sh0005, -16'sh0002, 16'sh0001};
    // Rows: written cfg1 value, then expected status without underrun.
    logic [15:0] rows [19] = '{16'hc804, 16'hd008, 16'hd80c, 16'he010,
        16'he814, 16'hf018, 16'hf81c, 16'hc000, 16'hcc24, 16'h8808, 16'h9010,
        16'h9818, 16'h9c38, 16'ha001, 16'h4810, 16'h4420, 16'h5001, 16'h0401,
        16'h0000};

    always #5 pclk = ~pclk;

    interp_modulator_invsinc_path dut (.pclk, .presetn, .paddr, .psel,
        .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr, .port1_word,
        .port2_word, .in_valid, .in_ready, .dac_i, .dac_q);
    baseband_source src (.pclk, .presetn, .in_ready, .stall, .interleave,
        .i_word, .q_word, .port1_word, .port2_word, .in_valid);

    task summarize;
        if (err_total == 0 && checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : summarize

    task chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            err_total++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task apb(input logic [7:0] a, input logic w, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    function automatic logic [31:0] mix(input logic [2:0] p);
        logic signed [31:0] c, s, a, b;
        c = cq[p];
        s = cq[p + 3'd6];
        a = (i_word * c + q_word * s + 32'sd8192) >>> 14;
        b = (q_word * c - i_word * s + 32'sd8192) >>> 14;
        return {a[15:0], b[15:0]};
    endfunction : mix

    task seq(input logic [2:0] step);
        logic [2:0] p;
        int k;
        repeat (30) @(posedge pclk);
        @(negedge pclk);
        p = 3'd0;
        for (k = 0; k < 8 && {dac_i, dac_q} !== mix(p); k++) p++;
        for (k = 0; k < 8; k++) begin
            chk({dac_i, dac_q}, mix(p));
            p = p + step;
            @(negedge pclk);
        end
    endtask : seq

    task hold(input logic [31:0] exp);
        repeat (30) @(posedge pclk);
        repeat (8) begin
            @(negedge pclk);
            chk({dac_i, dac_q}, exp);
        end
        @(posedge pclk);
    endtask : hold

    task pulse(input logic en);
        int n;
        sample_t e;
        i_word <= 16'sh0000;
        q_word <= 16'sh0000;
        repeat (20) @(posedge pclk);
        i_word <= 16'sh0100;
        @(posedge pclk);
        i_word <= 16'sh0000;
        for (n = 0; n < 30 && dac_i === 16'sh0000; n++) @(negedge pclk);
        for (n = 0; n < 9; n++) begin
            e = en ? isinc[n] : (n == 0 ? 16'sh0100 : 16'sh0000);
            chk({16'h0, dac_i}, {16'h0, e});
            @(negedge pclk);
        end
        @(posedge pclk);
    endtask : pulse

    initial begin
        repeat (20000) @(posedge pclk);
        err_total++;
        summarize();
    end

    initial begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        apb(8'h04, 1'b0, 32'h0);
        chk(rd, 32'h0);
        apb(8'h08, 1'b0, 32'h0);
        chk(rd, 32'h0);
        foreach (rows[j]) begin
            apb(8'h04, 1'b1, {24'h0, rows[j][15:8]});
            apb(8'h0c, 1'b0, 32'h0);
            chk(rd & 32'h3d, {24'h0, rows[j][7:0]});
            if (!rows[j][5]) seq(rows[j][4:2]);
        end
        // Unmapped and misaligned accesses are refused and write nothing.
        apb(8'h10, 1'b0, 32'h0);
        chk({rd[30:0], err}, 32'h1);
        apb(8'h05, 1'b1, 32'hc8);
        chk({rd[30:0], err}, 32'h1);
        apb(8'h04, 1'b0, 32'h0);
        chk(rd, 32'h0);
        pulse(1'b0);
        apb(8'h08, 1'b1, 32'h08);
        pulse(1'b1);
        i_word <= 16'sh1000;
        q_word <= 16'sh0800;
        hold({16'h0ad8, 16'h056c});
        apb(8'h08, 1'b1, 32'h40);
        interleave <= 1'b1;
        hold({16'h1000, 16'h0800});
        apb(8'h04, 1'b1, 32'hd0);
        apb(8'h08, 1'b1, 32'h20);
        interleave <= 1'b0;
        hold({16'h1000, 16'h0000});
        stall <= 1'b1;
        repeat (20) @(posedge pclk);
        stall <= 1'b0;
        apb(8'h0c, 1'b0, 32'h0);
        chk(rd & 32'h2, 32'h2);
        apb(8'h0c, 1'b1, 32'h2);
        apb(8'h0c, 1'b0, 32'h0);
        chk(rd & 32'h2, 32'h0);
        presetn <= 1'b0;
        @(posedge pclk);
        presetn <= 1'b1;
        apb(8'h08, 1'b0, 32'h0);
        chk(rd, 32'h0);
        summarize();
    end
endmodule : interp_modulator_invsinc_path_bench

// ### testbench/interp_path_sva.sv
/* Checker of APB answer timing and sample slot spacing.
   Bound to the path's top module; sees only its ports. */
`timescale 1ns/100ps
module interp_path_sva (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic [7:0]  paddr,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        in_ready
);
    logic [1:0] fac;
    logic       take;
    assign take = psel && penable && pready && pwrite;
    // Shadow of the interpolation factor, so slot spacing can be judged.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fac <= 2'h0;
        end else if (take && paddr == 8'h04) begin
            fac <= pwdata[7:6];
        end
    end
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_one_wait: assert property (
        psel && penable && !pready |=> pready)
        else $error("pready not after one wait state");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    a_ready_cause: assert property (
        pready |-> $past(psel && penable))
        else $error("pready without access phase");
    a_rdata_quiet: assert property (!pready |-> prdata == 32'h0)
        else $error("prdata not zero outside answer");
    a_err_decode: assert property (
        pready |-> pslverr == !(paddr[1:0] == 2'h0
        && paddr[7:2] inside {6'h01, 6'h02, 6'h03}))
        else $error("pslverr does not match address");
    a_read_width: assert property (
        pready && !pwrite |-> prdata[31:8] == 24'h0)
        else $error("upper read bits not zero");
    a_full_rate: assert property (
        fac == 2'h0 && $past(fac) == 2'h0 && $past(presetn) |-> in_ready)
        else $error("in_ready low at unit factor");
    a_slot_gap: assert property (
        in_ready && fac == 2'h3 && $past(fac) == 2'h3
        |=> (!in_ready || fac != 2'h3) [*7])
        else $error("word slots closer than eight cycles");
    c_write: cover property (take);
    c_refused: cover property (pready && pslverr);
    c_slot8: cover property (in_ready && fac == 2'h3);
endmodule : interp_path_sva

bind interp_modulator_invsinc_path interp_path_sva u_sva (.pclk, .presetn,
    .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr,
    .in_ready);
